// ==== core/rupp_params.svh ====
// constants for the user program partition register block
// assumes inclusion by bare name from core files
`ifndef RUPP_PARAMS_SVH
`define RUPP_PARAMS_SVH

// register byte offsets
`define RUPP_OFF_UPB 12'h000
`define RUPP_OFF_UDB 12'h004
`define RUPP_OFF_RSZ 12'h008
`define RUPP_OFF_STAT 12'h00C
// field positions of the base fields
`define RUPP_BASE_MSB 15
`define RUPP_BASE_LSB 10
// reset values
`define RUPP_UPB_RST 6'h00
`define RUPP_UDB_RST 6'h00
`define RUPP_RSZ_RST 6'h00
// axi response codes
`define RUPP_RESP_OKAY 2'h0
`define RUPP_RESP_SLVERR 2'h2

`endif

// ==== core/rupp_pkg.sv ====
// types for the user program partition register block
// assumes nothing beyond the params header
package rupp_pkg;
   typedef logic [5:0] rupp_field_t;
   typedef enum {RUPP_W_IDLE, RUPP_W_RESP} rupp_wstate_t;
endpackage

// ==== core/rupp_check.sv ====
// partition ordering checker: compares programmed base fields
// assumes all fields are registered in the same clock domain
`timescale 1ns/1ps
module rupp_check
   import rupp_pkg::*;
(
   // fields in 1 KB units
   input wire rupp_field_t upb_i,
   input wire rupp_field_t udb_i,
   input wire rupp_field_t rsz_i,
   // flags
   output logic order_bad_o,
   output logic size_bad_o
);
   // user program base must exceed user data base when in use
   assign order_bad_o = (upb_i != 6'h00) && (upb_i <= udb_i);
   // user program base must not exceed ram size setting
   assign size_bad_o = upb_i > rsz_i;
endmodule

// ==== core/rupp_regs.sv ====
// user program partition register block behind an axi4-lite slave
// Overview of operation
// - bits 31 to 16 of the user program base always read as zero.
// - bits 15 to 10 hold the writable six-bit user program start, active when non-zero.
// - bits 9 to 0 read as zero so the boundary moves in 1 KB steps.
// - reset clears the user program base, giving all ram to kernel data.
// assumes a single clock, an axi4-lite master, one write and one read at a time
`timescale 1ns/1ps
`include "rupp_params.svh"
module rupp_regs
   import rupp_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // write address and data
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // read address
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // read data
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // partition outputs
   output logic [31:0] USER_PROG_BASE_O,
   output logic USER_PROG_EN_O
);
   //----------------------------------------
   // state
   //----------------------------------------
   rupp_field_t upb_reg, udb_reg, rsz_reg;
   rupp_wstate_t wstate_reg;
   logic aw_got_reg, w_got_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic order_bad, size_bad;
   logic do_write;

   // pack a base field into a full register word with fixed zeros
   function automatic logic [31:0] base_word(input rupp_field_t f);
      base_word = {16'h0000, f, 10'h000};
   endfunction

   // field update honouring byte strobes over bits 15:10 only
   function automatic rupp_field_t merge_field(input rupp_field_t old,
         input logic [31:0] d, input logic [3:0] s);
      merge_field = s[1] ? d[`RUPP_BASE_MSB:`RUPP_BASE_LSB] : old;
   endfunction

   //----------------------------------------
   // write channel
   //----------------------------------------
   assign do_write = aw_got_reg && w_got_reg && (wstate_reg == RUPP_W_IDLE);

   // accept address and data in either order
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR_I;
         end else if (do_write) begin
            aw_got_reg <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_got_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
         end else if (do_write) begin
            w_got_reg <= 1'b0;
         end
      end
   end

   // ready flags registered, low while holding a beat or answering
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
      end else begin
         S_AXI_AWREADY_O <= !aw_got_reg && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            && (wstate_reg == RUPP_W_IDLE);
         S_AXI_WREADY_O <= !w_got_reg && !(S_AXI_WVALID_I && S_AXI_WREADY_O)
            && (wstate_reg == RUPP_W_IDLE);
      end
   end

   // response state machine
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wstate_reg <= RUPP_W_IDLE;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= `RUPP_RESP_OKAY;
      end else begin
         case (wstate_reg)
            RUPP_W_IDLE: begin
               if (do_write) begin
                  wstate_reg <= RUPP_W_RESP;
                  S_AXI_BVALID_O <= 1'b1;
                  case (awaddr_reg)
                     `RUPP_OFF_UPB, `RUPP_OFF_UDB, `RUPP_OFF_RSZ, `RUPP_OFF_STAT:
                        S_AXI_BRESP_O <= `RUPP_RESP_OKAY;
                     default: S_AXI_BRESP_O <= `RUPP_RESP_SLVERR;
                  endcase
               end
            end
            RUPP_W_RESP: begin
               if (S_AXI_BREADY_I) begin
                  wstate_reg <= RUPP_W_IDLE;
                  S_AXI_BVALID_O <= 1'b0;
               end
            end
            default: wstate_reg <= RUPP_W_IDLE;
         endcase
      end
   end

   //----------------------------------------
   // registers
   //----------------------------------------
   // base fields, cleared at reset
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         upb_reg <= `RUPP_UPB_RST;
         udb_reg <= `RUPP_UDB_RST;
         rsz_reg <= `RUPP_RSZ_RST;
      end else if (do_write) begin
         case (awaddr_reg)
            `RUPP_OFF_UPB: upb_reg <= merge_field(upb_reg, wdata_reg, wstrb_reg);
            `RUPP_OFF_UDB: udb_reg <= merge_field(udb_reg, wdata_reg, wstrb_reg);
            `RUPP_OFF_RSZ: rsz_reg <= merge_field(rsz_reg, wdata_reg, wstrb_reg);
            default: ;
         endcase
      end
   end

   // ordering checker for software mistakes
   rupp_check u_rupp_check (
      .upb_i(upb_reg),
      .udb_i(udb_reg),
      .rsz_i(rsz_reg),
      .order_bad_o(order_bad),
      .size_bad_o(size_bad)
   );

   //----------------------------------------
   // read channel
   //----------------------------------------
   // one-cycle read answer, held until taken
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h00000000;
         S_AXI_RRESP_O <= `RUPP_RESP_OKAY;
      end else if (S_AXI_RVALID_O) begin
         S_AXI_ARREADY_O <= 1'b0;
         if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
         end
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RRESP_O <= `RUPP_RESP_OKAY;
         case (S_AXI_ARADDR_I)
            `RUPP_OFF_UPB: S_AXI_RDATA_O <= base_word(upb_reg);
            `RUPP_OFF_UDB: S_AXI_RDATA_O <= base_word(udb_reg);
            `RUPP_OFF_RSZ: S_AXI_RDATA_O <= base_word(rsz_reg);
            `RUPP_OFF_STAT: S_AXI_RDATA_O <= {30'h00000000, size_bad, order_bad};
            default: begin
               S_AXI_RDATA_O <= 32'h00000000;
               S_AXI_RRESP_O <= `RUPP_RESP_SLVERR;
            end
         endcase
      end else begin
         S_AXI_ARREADY_O <= 1'b1;
      end
   end

   //----------------------------------------
   // partition outputs
   //----------------------------------------
   // registered copy of the boundary for the bus matrix
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         USER_PROG_BASE_O <= 32'h00000000;
         USER_PROG_EN_O <= 1'b0;
      end else begin
         USER_PROG_BASE_O <= base_word(upb_reg);
         USER_PROG_EN_O <= upb_reg != 6'h00;
      end
   end

   //----------------------------------------
   // assertions
   //----------------------------------------
   sequence s_upb_write;
      do_write && awaddr_reg == `RUPP_OFF_UPB && wstrb_reg[1];
   endsequence

   a_upper_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      USER_PROG_BASE_O[31:16] == 16'h0000) else $error("upper bits not zero");
   // status reads carry flags in the low bits, so only user program base reads are watched
   a_low_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == `RUPP_OFF_UPB)
      |=> (S_AXI_RDATA_O[9:0] == 10'h000 && S_AXI_RDATA_O[31:16] == 16'h0000))
      else $error("fixed bits of base read not zero");
   a_field_write: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      s_upb_write |=> ##1 USER_PROG_BASE_O[15:10] == $past(wdata_reg[15:10], 2))
      else $error("field not written");
   a_only_field: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      !(do_write && awaddr_reg == `RUPP_OFF_UPB && wstrb_reg[1]) |=> $stable(upb_reg))
      else $error("field changed without write");
   a_reset_zero: assert property (@(posedge REF_CLK_I)
      $rose(RST_N_I) |-> upb_reg == 6'h00) else $error("field not cleared");
   a_order_flag: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      (upb_reg != 6'h00 && upb_reg <= udb_reg) |-> order_bad) else $error("order flag lost");
   a_size_flag: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      size_bad == (upb_reg > rsz_reg)) else $error("size flag wrong");
   a_en_follows: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      (upb_reg == 6'h00) |=> !USER_PROG_EN_O) else $error("enable without base");
endmodule

// ==== sim/ram_user_program_partition_tb.sv ====
// self-checking bench for the user program partition register block
// assumes rupp_regs with an axi4-lite slave, 12-bit byte addresses
`timescale 1ns/1ps
`include "rupp_params.svh"
module ram_user_program_partition_tb
   import rupp_pkg::*;
;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, prog_en;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, prog_base;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int miscompares = 0;
   int checked = 0;
   logic [1:0] wq[$];
   logic [33:0] rq[$];
   rupp_field_t fld;

   rupp_regs u_rupp_regs (
      .REF_CLK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .USER_PROG_BASE_O(prog_base), .USER_PROG_EN_O(prog_en)
   );

   // ----------------------------------------
   // clock, verdict and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up();
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // cut a hang short well past the expected run
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   // ----------------------------------------
   // bus master tasks, expectations queued
   // ----------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic done;
      done = 1'b0;
      wq.push_back(er);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            done = 1'b1;
            bready <= 1'b0;
         end
      end
      // let an edge pass so the next call never re-raises bready in this step
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      rq.push_back({er, ed});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            done = 1'b1;
            rready <= 1'b0;
         end
      end
      // let an edge pass so the next call never re-raises rready in this step
      @(posedge clk);
   endtask

   // partition outputs follow the field one cycle late
   task automatic outs(input rupp_field_t f);
      repeat (2) @(posedge clk);
      check({2'b0, prog_base}, {18'h0, f, 10'h000}, "base out");
      check({33'h0, prog_en}, {33'h0, f != 6'h00}, "enable out");
   endtask

   // ----------------------------------------
   // response monitor: oldest note per answer
   // ----------------------------------------
   always @(posedge clk) begin
      if (bvalid && bready) check({32'h0, bresp}, {32'h0, wq.pop_front()}, "bresp");
      if (rvalid && rready) check({rresp, rdata}, rq.pop_front(), "read");
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      logic [31:0] d;
      logic [3:0] s;
      rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
      d = $urandom(32'h35BE);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`RUPP_OFF_UPB, 32'h0, `RUPP_RESP_OKAY);
      outs(6'h00);
      // all ones: only the six-bit field sticks
      wr(`RUPP_OFF_UPB, 32'hFFFFFFFF, 4'hF, `RUPP_RESP_OKAY);
      rd(`RUPP_OFF_UPB, 32'h0000FC00, `RUPP_RESP_OKAY);
      fld = 6'h3F;
      outs(fld);
      // random data and strobes back to back
      for (int i = 0; i < 24; i++) begin
         d = $urandom;
         s = 4'($urandom);
         if (s[1]) fld = d[15:10];
         wr(`RUPP_OFF_UPB, d, s, `RUPP_RESP_OKAY);
         rd(`RUPP_OFF_UPB, {16'h0, fld, 10'h000}, `RUPP_RESP_OKAY);
         outs(fld);
      end
      wr(`RUPP_OFF_UPB, 32'h0, 4'hF, `RUPP_RESP_OKAY);
      outs(6'h00);
      // unmapped place refused, field untouched
      wr(12'h010, 32'hFFFFFFFF, 4'hF, `RUPP_RESP_SLVERR);
      rd(12'h010, 32'h0, `RUPP_RESP_SLVERR);
      rd(`RUPP_OFF_UPB, 32'h0, `RUPP_RESP_OKAY);
      // ordering and size flags, then a legal layout
      wr(`RUPP_OFF_UDB, 32'h00001000, 4'hF, `RUPP_RESP_OKAY);
      wr(`RUPP_OFF_RSZ, 32'h00000400, 4'hF, `RUPP_RESP_OKAY);
      wr(`RUPP_OFF_UPB, 32'h00000800, 4'hF, `RUPP_RESP_OKAY);
      rd(`RUPP_OFF_STAT, 32'h3, `RUPP_RESP_OKAY);
      wr(`RUPP_OFF_UDB, 32'h00000400, 4'hF, `RUPP_RESP_OKAY);
      wr(`RUPP_OFF_RSZ, 32'h00002000, 4'hF, `RUPP_RESP_OKAY);
      rd(`RUPP_OFF_STAT, 32'h0, `RUPP_RESP_OKAY);
      outs(6'h02);
      // reset in mid-run clears the field
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      outs(6'h00);
      rd(`RUPP_OFF_UPB, 32'h0, `RUPP_RESP_OKAY);
      repeat (3) @(posedge clk);
      wrap_up();
   end
endmodule
